// [include/dto_pkg.sv]
// Purpose: constants for the ds3 transmit overhead serial insertion port
// Assumes: one channel, ds3 frame of 7 subframes x 8 blocks x 85 bits
// Notes:   overhead index n equals the overhead clock edge count since frame
//
// Operation
// - insert enable high: capture data on falling
// - insert enable low: data ignored
// - insert on fixed position is ignored
// - accepted bit goes into next frame
// - clock rises one bit before overhead
// - clock edge for every overhead bit
// - boundary marker high on last bit
// - frame 4760 bits, 56 overhead
// - accept X, C, DL, UDL, FEBE positions only
// - F, M, P always generated inside
package dto_pkg;

    // ***************************************************************
    // frame geometry
    // ***************************************************************
    localparam int FRAME_BITS = 4760;
    localparam int OH_BITS    = 56;
    localparam int BLOCK_BITS = FRAME_BITS / OH_BITS;
    localparam logic [6:0] BLOCK_LAST = 7'h54;   // 84, last bit of a block
    localparam logic [5:0] OH_LAST    = 6'h37;   // 55, last overhead index
    localparam logic [2:0] SUB_P0     = 3'h2;    // first subframe with a p bit
    localparam logic [2:0] SUB_P1     = 3'h3;
    localparam logic [2:0] SUB_M2     = 3'h5;    // subframe carrying m = 1

    // insertable overhead indices, subframe 0 in the low byte
    localparam logic [55:0] ACCEPT_MASK = 56'h54545454545555;

    // ***************************************************************
    // level settings crossing into the line domain
    // ***************************************************************
    localparam int CFG_X    = 0;
    localparam int CFG_FEAC = 1;
    localparam int CFG_FEBE = 2;
    localparam int CFG_FILL = 3;
    localparam int CFG_W    = 4;
    localparam logic [3:0] CFG_RESET = 4'hD;     // x, febe and fill idle high

endpackage

// [rtl/dto_overhead_insert.sv]
// Purpose: serial overhead insertion port of a ds3 transmit framer
// Assumes: clk_line is the line bit clock; partner logic runs off the
//          overhead clock output, so its pins are synchronous to clk_line
// Notes:   overhead clock is high for the bit before each overhead bit
`timescale 1ns/1ps

module dto_overhead_insert #(
    parameter int SYNC_STAGES = 2
) (
    // system side
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic x_value,
    input  wire logic feac_value,
    input  wire logic febe_value,
    input  wire logic cbit_fill,
    output logic      frame_tick,
    // line side
    input  wire logic clk_line,
    input  wire logic payload_data_in,
    output logic      payload_take,
    output logic      tx_line_data,
    // overhead insertion port
    input  wire logic overhead_serial_data_in,
    input  wire logic overhead_insert_enable,
    output logic      overhead_bit_clock_out,
    output logic      overhead_frame_boundary_out
);

    // ***************************************************************
    // elaboration checks
    // ***************************************************************
    if (SYNC_STAGES != 2) begin : g_bad_sync
        $error("dto_overhead_insert: only two synchroniser stages supported");
    end
    if (dto_pkg::BLOCK_BITS * dto_pkg::OH_BITS != dto_pkg::FRAME_BITS) begin : g_bad_geo
        $error("dto_overhead_insert: frame geometry inconsistent");
    end

    // ***************************************************************
    // line domain reset release
    // ***************************************************************
    logic rst_line_meta;
    logic rst_line_b;

    // asserts at once, releases two line edges later
    always_ff @(posedge clk_line or negedge rst_b) begin
        if (!rst_b) begin
            rst_line_meta <= 1'b0;
            rst_line_b    <= 1'b0;
        end else begin
            rst_line_meta <= 1'b1;
            rst_line_b    <= rst_line_meta;
        end
    end

    // ***************************************************************
    // settings crossing into the line domain
    // ***************************************************************
    logic [dto_pkg::CFG_W-1:0] cfg_meta;
    logic [dto_pkg::CFG_W-1:0] cfg;

    // independent slow levels, so per-bit two flop sync is enough
    always_ff @(posedge clk_line or negedge rst_line_b) begin
        if (!rst_line_b) begin
            cfg_meta <= dto_pkg::CFG_RESET;
            cfg      <= dto_pkg::CFG_RESET;
        end else begin
            cfg_meta <= {cbit_fill, febe_value, feac_value, x_value};
            cfg      <= cfg_meta;
        end
    end

    // ***************************************************************
    // frame position
    // ***************************************************************
    logic [6:0] block_pos;
    logic [5:0] oh_idx;
    logic [6:0] next_block_pos;
    logic [5:0] next_oh_idx;
    logic       last_bit;
    logic       oh_next;

    // position of the bit that goes out at the coming edge
    always_comb begin
        last_bit = (oh_idx == dto_pkg::OH_LAST) && (block_pos == dto_pkg::BLOCK_LAST);
        if (block_pos == dto_pkg::BLOCK_LAST) begin
            next_block_pos = 7'h00;
            next_oh_idx    = last_bit ? 6'h00 : oh_idx + 6'h01;
        end else begin
            next_block_pos = block_pos + 7'h01;
            next_oh_idx    = oh_idx;
        end
        oh_next = (next_block_pos == 7'h00);
    end

    // 56 blocks of 85 bits, one overhead bit heading each block
    always_ff @(posedge clk_line or negedge rst_line_b) begin
        if (!rst_line_b) begin
            // one bit early, so even the first overhead bit gets its clock
            block_pos <= dto_pkg::BLOCK_LAST - 7'h01;
            oh_idx    <= dto_pkg::OH_LAST;
        end else begin
            block_pos <= next_block_pos;
            oh_idx    <= next_oh_idx;
        end
    end

    // ***************************************************************
    // overhead clock and frame boundary marker
    // ***************************************************************
    // high for the bit before every overhead bit, fixed ones included
    always_ff @(posedge clk_line or negedge rst_line_b) begin
        if (!rst_line_b) begin
            overhead_bit_clock_out      <= 1'b0;
            overhead_frame_boundary_out <= 1'b0;
        end else begin
            overhead_bit_clock_out      <= (next_block_pos == dto_pkg::BLOCK_LAST);
            overhead_frame_boundary_out <= (next_oh_idx == dto_pkg::OH_LAST)
                                           && (next_block_pos == dto_pkg::BLOCK_LAST);
        end
    end

    // ***************************************************************
    // capture and next-frame insertion store
    // ***************************************************************
    logic [55:0] cap_vld;
    logic [55:0] cap_val;
    logic [55:0] use_vld;
    logic [55:0] use_val;
    logic        cap_wr;
    logic        swap;

    // falling overhead clock edge is the edge entering an overhead bit
    assign cap_wr = oh_next && overhead_insert_enable
                    && dto_pkg::ACCEPT_MASK[next_oh_idx];
    assign swap   = last_bit;

    for (genvar i = 0; i < dto_pkg::OH_BITS; i++) begin : g_entry
        // a capture at the frame turn lands in the fresh frame's store
        always_ff @(posedge clk_line or negedge rst_line_b) begin
            if (!rst_line_b) begin
                cap_vld[i] <= 1'b0;
                cap_val[i] <= 1'b0;
            end else if (cap_wr && (next_oh_idx == 6'(i))) begin
                cap_vld[i] <= 1'b1;
                cap_val[i] <= overhead_serial_data_in;
            end else if (swap) begin
                cap_vld[i] <= 1'b0;
            end
        end

        // previous frame's captures drive this frame
        always_ff @(posedge clk_line or negedge rst_line_b) begin
            if (!rst_line_b) begin
                use_vld[i] <= 1'b0;
                use_val[i] <= 1'b0;
            end else if (swap) begin
                use_vld[i] <= cap_vld[i];
                use_val[i] <= cap_val[i];
            end
        end
    end

    // ***************************************************************
    // internally generated overhead
    // ***************************************************************
    logic       pay_par;
    logic       p_val;
    logic       int_bit;
    logic [2:0] sub;
    logic [2:0] pos;

    // parity over the payload of one frame, used in the next
    always_ff @(posedge clk_line or negedge rst_line_b) begin
        if (!rst_line_b) begin
            pay_par <= 1'b0;
            p_val   <= 1'b0;
        end else if (swap) begin
            pay_par <= 1'b0;
            p_val   <= pay_par;
        end else if (!oh_next) begin
            pay_par <= pay_par ^ payload_data_in;
        end
    end

    // value the framer sends when nothing was inserted
    always_comb begin
        sub = next_oh_idx[5:3];
        pos = next_oh_idx[2:0];
        int_bit = cfg[dto_pkg::CFG_FILL];
        if (pos[0]) begin
            int_bit = (pos == 3'h1) || (pos == 3'h7);
        end else if (pos == 3'h0) begin
            if (sub == dto_pkg::SUB_P0 || sub == dto_pkg::SUB_P1) begin
                int_bit = p_val;
            end else if (sub > dto_pkg::SUB_P1) begin
                int_bit = (sub == dto_pkg::SUB_M2);
            end else begin
                int_bit = cfg[dto_pkg::CFG_X];
            end
        end else if (sub == 3'h0 && pos == 3'h6) begin
            int_bit = cfg[dto_pkg::CFG_FEAC];
        end else if (sub == dto_pkg::SUB_P0) begin
            int_bit = p_val;
        end else if (sub == dto_pkg::SUB_P1) begin
            int_bit = cfg[dto_pkg::CFG_FEBE];
        end
    end

    // ***************************************************************
    // line output
    // ***************************************************************
    logic sel_vld;
    logic sel_val;

    // at the frame turn the store has not swapped yet, so read ahead
    assign sel_vld      = swap ? cap_vld[next_oh_idx] : use_vld[next_oh_idx];
    assign sel_val      = swap ? cap_val[next_oh_idx] : use_val[next_oh_idx];
    assign payload_take = rst_line_b && !oh_next;

    always_ff @(posedge clk_line or negedge rst_line_b) begin
        if (!rst_line_b) begin
            tx_line_data <= 1'b0;
        end else if (!oh_next) begin
            tx_line_data <= payload_data_in;
        end else begin
            tx_line_data <= sel_vld ? sel_val : int_bit;
        end
    end

    // ***************************************************************
    // frame event into the system domain
    // ***************************************************************
    logic frame_tgl;
    logic tgl_meta;
    logic tgl_sync;
    logic tgl_prev;

    always_ff @(posedge clk_line or negedge rst_line_b) begin
        if (!rst_line_b) begin
            frame_tgl <= 1'b0;
        end else if (swap) begin
            frame_tgl <= ~frame_tgl;
        end
    end

    // toggle crossing; the meta flop feeds only the sync flop
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tgl_meta   <= 1'b0;
            tgl_sync   <= 1'b0;
            tgl_prev   <= 1'b0;
            frame_tick <= 1'b0;
        end else begin
            tgl_meta   <= frame_tgl;
            tgl_sync   <= tgl_meta;
            tgl_prev   <= tgl_sync;
            frame_tick <= tgl_sync ^ tgl_prev;
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    logic [5:0]  chk_edges;
    logic [12:0] chk_bits;
    logic        chk_seen;
    logic [5:0]  chk_idx;
    logic        chk_dat;

    // edge and bit counts since the last boundary marker
    always_ff @(posedge clk_line or negedge rst_line_b) begin
        if (!rst_line_b) begin
            chk_edges <= 6'h00;
            chk_bits  <= 13'h0000;
            chk_seen  <= 1'b0;
            chk_idx   <= 6'h00;
            chk_dat   <= 1'b0;
        end else begin
            chk_idx <= next_oh_idx;
            chk_dat <= overhead_serial_data_in;
            if (overhead_frame_boundary_out) begin
                chk_seen  <= 1'b1;
                chk_bits  <= 13'h0000;
                chk_edges <= 6'h00;
            end else begin
                chk_bits <= chk_bits + 13'h0001;
                if ($rose(overhead_bit_clock_out)) begin
                    chk_edges <= chk_edges + 6'h01;
                end
            end
        end
    end

    clock_rise_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
        $rose(overhead_bit_clock_out) |=> (block_pos == 7'h00) && $fell(overhead_bit_clock_out))
        else $error("overhead clock rise not one bit before overhead");
    edges_per_frame_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
        (overhead_frame_boundary_out && chk_seen) |-> (chk_edges == dto_pkg::OH_LAST))
        else $error("overhead clock edge count per frame wrong");
    boundary_last_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
        overhead_frame_boundary_out |-> overhead_bit_clock_out ##1 (oh_idx == 6'h00))
        else $error("boundary marker not on last frame bit");
    frame_length_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
        (overhead_frame_boundary_out && chk_seen) |-> (chk_bits == 13'(dto_pkg::FRAME_BITS - 1)))
        else $error("frame length not 4760 bits");
    capture_taken_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
        (cap_wr && !swap) |=> cap_vld[chk_idx] && (cap_val[chk_idx] == chk_dat))
        else $error("enabled overhead bit not captured");
    capture_idle_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
        (!overhead_insert_enable && !swap) |=> $stable(cap_vld) && $stable(cap_val))
        else $error("overhead data captured while disabled");
    fixed_reject_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
        ((cap_vld | use_vld) & ~dto_pkg::ACCEPT_MASK) == 56'h0)
        else $error("non-insertable overhead position accepted");
    fbit_pattern_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
        (block_pos == 7'h00 && oh_idx[0]) |->
        (tx_line_data == (oh_idx[2:0] == 3'h1 || oh_idx[2:0] == 3'h7)))
        else $error("f bit value wrong");
    m_bit_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
        (block_pos == 7'h00 && oh_idx[2:0] == 3'h0 && oh_idx[5:3] > 3'h3)
        |-> (tx_line_data == (oh_idx[5:3] == 3'h5)))
        else $error("m bit value wrong");
    clock_lead_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
        (block_pos == 7'h00) |-> $past(overhead_bit_clock_out))
        else $error("overhead bit without a leading clock pulse");
    next_frame_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
        (block_pos == 7'h00 && use_vld[oh_idx]) |-> (tx_line_data == use_val[oh_idx]))
        else $error("inserted bit not sent in next frame");
    frame_tick_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        frame_tick |=> !frame_tick)
        else $error("frame tick longer than one cycle");

endmodule // dto_overhead_insert

// [tb/dto_term_model.sv]
// Purpose: terminal equipment model feeding the overhead insertion port
// Assumes: runs only off the overhead clock and frame boundary outputs
// Notes:   while active it offers ins_val at every index, fixed ones too
`timescale 1ns/1ps

module dto_term_model (
    // overhead port
    input  wire logic        overhead_bit_clock_out,
    input  wire logic        overhead_frame_boundary_out,
    output logic             overhead_serial_data_in,
    output logic             overhead_insert_enable,
    // bench control
    input  wire logic        active,
    input  wire logic [55:0] ins_val
);
    int   idx   = 0;
    logic en_q  = 1'b0;    // quiet until the first overhead clock
    logic dat_q = 1'b0;

    // ***************************************************************
    // edge counting and drive
    // ***************************************************************
    // settle first: clock and boundary change on the same line edge;
    // on the drop, release enable and flip data so a stale value is useless
    always @(overhead_bit_clock_out) begin
        #2;
        if (overhead_bit_clock_out === 1'b1) begin
            idx   = (overhead_frame_boundary_out === 1'b1) ? 0 : (idx + 1) % 56;
            en_q  = active;
            dat_q = ins_val[idx];
        end else begin
            en_q  = 1'b0;
            dat_q = ~dat_q;
        end
    end

    assign overhead_insert_enable  = en_q;
    assign overhead_serial_data_in = dat_q;
endmodule // dto_term_model

// [tb/dto_overhead_insert_bench.sv]
// Purpose: self-checking bench for the overhead insertion port
// Assumes: payload held at zero so parity bits repeat frame to frame
// Notes:   each frame is followed bit by bit; about five frames in all
`timescale 1ns/1ps

module dto_overhead_insert_bench;
    // ***************************************************************
    // clocks, pins and counters
    // ***************************************************************
    logic        clk_sys  = 1'b0;
    logic        clk_line = 1'b0;
    logic        rst_b    = 1'b0;
    logic        frame_tick;
    logic        tx_line_data;
    logic        ovh_data;
    logic        ovh_en;
    logic        ovh_clk;
    logic        ovh_bnd;
    logic        take;
    logic        active   = 1'b0;
    logic [55:0] ins_val  = '0;
    logic [55:0] ref_oh;
    logic [55:0] got_oh;
    logic [55:0] m_val;
    logic [55:0] m_known;
    logic [55:0] m_ins;
    int          fail_count = 0;
    int          tests_run  = 0;
    int          ticks      = 0;
    int          cycles     = 0;

    always #4 clk_sys = ~clk_sys;
    // line rises at 40 + 80k, never on a rising system edge
    always #40 clk_line = ~clk_line;

    // settings fixed unlike their reset levels except fill, payload zero
    dto_overhead_insert DUT (
        .clk_sys(clk_sys), .rst_b(rst_b), .x_value(1'b0), .feac_value(1'b1),
        .febe_value(1'b0), .cbit_fill(1'b1), .frame_tick(frame_tick),
        .clk_line(clk_line), .payload_data_in(1'b0), .payload_take(take),
        .tx_line_data(tx_line_data), .overhead_serial_data_in(ovh_data),
        .overhead_insert_enable(ovh_en), .overhead_bit_clock_out(ovh_clk),
        .overhead_frame_boundary_out(ovh_bnd));

    dto_term_model PARTNER (
        .overhead_bit_clock_out(ovh_clk), .overhead_frame_boundary_out(ovh_bnd),
        .overhead_serial_data_in(ovh_data), .overhead_insert_enable(ovh_en),
        .active(active), .ins_val(ins_val));

    // ***************************************************************
    // monitors, compares and verdict
    // ***************************************************************
    always @(posedge clk_sys) if (frame_tick === 1'b1) ticks++;

    // cut a hang short well past five frames of line cycles
    always @(posedge clk_line) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            results();
        end
    end

    task automatic check_bits(string what, logic [55:0] exp, logic [55:0] seen);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_count(string what, int exp, int seen);
        tests_run++;
        if (seen != exp) begin
            fail_count++;
            $display("Error %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    task automatic results();
        if (fail_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // internal values for the fixed settings; known leaves p and cp out
    function automatic void model(output logic [55:0] val, output logic [55:0] known,
                                  output logic [55:0] ins);
        for (int i = 0; i < 56; i++) begin
            ins[i]   = (i % 2 == 0) && !(i inside {16, 24, 32, 40, 48});
            known[i] = !(i inside {16, 18, 20, 22, 24});
            if (i % 2 == 1) val[i] = (i % 8 == 1) || (i % 8 == 7);
            else if (i inside {32, 40, 48}) val[i] = (i == 40);
            else if (i inside {0, 8, 26, 28, 30}) val[i] = 1'b0;
            else val[i] = 1'b1;
        end
    endfunction

    // wait for a boundary bit, bounded by a little over one frame
    task automatic sync_frame();
        int k;
        k = 0;
        do begin
            @(posedge clk_line);
            #1;
            k++;
        end while (ovh_bnd !== 1'b1 && k < 6000);
        check_count("boundary found", 1, int'(ovh_bnd === 1'b1));
    endtask

    // follow one frame from just after a boundary bit to the next one
    task automatic frame(output logic [55:0] oh);
        logic prev;
        int   n;
        int   highs;
        int   bnd_at;
        int   takes;
        prev   = ovh_clk;
        n      = 0;
        highs  = 0;
        bnd_at = 0;
        takes  = 0;
        for (int c = 1; c <= 4760; c++) begin
            @(posedge clk_line);
            #1;
            if (prev === 1'b1 && n < 56) begin
                oh[n] = tx_line_data;
                n++;
            end
            // a clock held longer than one bit inflates the count
            if (ovh_clk === 1'b1) highs = highs + (prev === 1'b1 ? 100 : 1);
            if (ovh_bnd === 1'b1) bnd_at = (ovh_clk === 1'b1) ? c : -c;
            if (take === 1'b1) takes++;
            prev = ovh_clk;
        end
        check_count("clock pulses per frame", 56, highs);
        check_count("payload slots per frame", 4704, takes);
        check_count("boundary cycle", 4760, bnd_at);
    endtask

    // ***************************************************************
    // scenarios
    // ***************************************************************
    task automatic scen_idle();
        frame(ref_oh);
        check_bits("internal overhead", m_val & m_known, ref_oh & m_known);
    endtask

    task automatic scen_insert();
        ticks   = 0;
        ins_val = ~ref_oh;
        active  = 1'b1;
        frame(got_oh);
        check_bits("frame of capture", ref_oh, got_oh);
        active = 1'b0;
        frame(got_oh);
        check_bits("inserted frame", ref_oh ^ m_ins, got_oh);
    endtask

    task automatic scen_disabled();
        frame(got_oh);
        check_bits("enable low frame", ref_oh, got_oh);
        check_count("frame ticks", 3, ticks);
    endtask

    initial begin
        model(m_val, m_known, m_ins);
        repeat (5) @(posedge clk_line);
        #1;
        rst_b = 1'b1;
        sync_frame();
        frame(got_oh);  // warm-up so parity has a settled source frame
        scen_idle();
        scen_insert();
        scen_disabled();
        results();
    end
endmodule // dto_overhead_insert_bench
